/* shared/uepr_regs_regs.vh */
// register indices, field positions and reset values of the endpoint
// register block; byte address on the bus is four times the index
`ifndef UEPR_REGS_REGS_VH
`define UEPR_REGS_REGS_VH
`define UEPR_NUM_EP       3
`define UEPR_FIFO_DEPTH   8
`define UEPR_IDX_FNUM_LO  8'hBA
`define UEPR_IDX_FNUM_HI  8'hBB
`define UEPR_IDX_IRQ_EN   8'hC2
`define UEPR_IDX_EP_SEL   8'hC7
`define UEPR_IDX_STATUS   8'hCE
`define UEPR_IDX_DATA     8'hCF
`define UEPR_IDX_FLUSH    8'hD5
`define UEPR_IDX_BYCNT    8'hE2
`define UEPR_IDX_IRQ_FLAG 8'hF8
`define UEPR_ST_TXDONE    0
`define UEPR_ST_OUTB0     1
`define UEPR_ST_SETUP     2
`define UEPR_ST_STALL     3
`define UEPR_ST_OUTB1     6
`define UEPR_FH_CRCERR    4
`define UEPR_FH_CRCOK     5
`define UEPR_RST_BYTE     8'h00
`define UEPR_RST_EP       3'h0
`define UEPR_RST_SEL      2'h0
`define UEPR_RST_CNT      7'h00
`define UEPR_RST_ST       5'h00
`define UEPR_RST_FHI      3'h0
`endif

/* design/uepr_top.v */
// endpoint register block of a full-speed usb function: flush, irq
// enable/flags, per-endpoint status, fifo data port, byte count, frame
// assumes an 8-bit classic wishbone master and a packet engine that
// gives one-cycle event pulses and streams bytes with valid/ready
`timescale 1ns/1ps
`include "uepr_regs_regs.vh"

module uepr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             clr_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg  [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg  [AW-1:0]    wp_reg;
  reg  [AW-1:0]    rp_reg;
  reg  [AW:0]      cnt_reg;
  wire             push;
  wire             pop;

  assign in_ready_o  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
  assign out_data_o  = mem_reg[rp_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_i) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                  : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                  : rp_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

module uepr_top #(
  parameter DEPTH = `UEPR_FIFO_DEPTH,
  parameter AW    = 3
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [9:0]  adr_i,
  input  wire        sel_i,
  input  wire [7:0]  dat_i,
  output wire [7:0]  dat_o,
  output wire        ack_o,
  output wire        usb_irq_o,
  input  wire [2:0]  ev_tx_done_i,
  input  wire [2:0]  ev_outb0_i,
  input  wire [2:0]  ev_outb1_i,
  input  wire [2:0]  ev_setup_i,
  input  wire [2:0]  ev_stall_crc_i,
  input  wire        rx_valid_i,
  input  wire [1:0]  rx_ep_i,
  input  wire [7:0]  rx_data_i,
  output wire        rx_ready_o,
  input  wire        rx_eop_i,
  input  wire [1:0]  tx_ep_i,
  input  wire        tx_ready_i,
  output wire        tx_valid_o,
  output wire [7:0]  tx_data_o,
  input  wire        sof_valid_i,
  input  wire        sof_crc_ok_i,
  input  wire [10:0] sof_frame_i
);
  reg  [7:0]  dat_reg;
  reg         ack_reg;
  reg  [2:0]  irq_en_reg;
  reg  [2:0]  flush_reg;
  reg  [1:0]  ep_sel_reg;
  reg  [7:0]  fnum_lo_reg;
  reg  [2:0]  fnum_hi_reg;
  reg         crc_ok_reg;
  reg         crc_err_reg;
  reg  [7:0]  rd_next;
  reg  [7:0]  st_rd;
  reg  [7:0]  fhi_rd;
  wire [7:0]  idx;
  wire        req;
  wire        wr;
  wire        sel_ok;
  wire        stall;
  wire        go;
  wire        hit_data;
  wire [2:0]  in_ready;
  wire [2:0]  out_valid;
  wire [23:0] out_data;
  wire [2:0]  flag;
  wire [14:0] st_w;
  wire [20:0] cnt_w;
  wire [2:0]  sw_push;
  wire [2:0]  sw_pop;
  wire [2:0]  rx_take;
  wire [2:0]  tx_take;
  wire [4:0]  st_sel;

  assign idx      = adr_i[9:2];
  assign req      = cyc_i & stb_i & ~ack_reg;
  assign wr       = we_i & sel_i;
  assign hit_data = (idx == `UEPR_IDX_DATA);
  assign sel_ok   = (ep_sel_reg != 2'h3);
  // a data write into a full fifo waits for room rather than dropping
  assign stall    = req & wr & hit_data & sel_ok & ~in_ready[ep_sel_reg];
  assign go       = req & ~stall;
  assign ack_o    = ack_reg;
  assign dat_o    = dat_reg;

  assign usb_irq_o = |(flag & irq_en_reg);

  // the engine is held off an endpoint while software owns that port
  assign rx_ready_o = (rx_ep_i == 2'h3) ? 1'b1 :
                      in_ready[rx_ep_i] & ~sw_push[rx_ep_i];
  assign tx_valid_o = (tx_ep_i == 2'h3) ? 1'b0 :
                      out_valid[tx_ep_i] & ~sw_pop[tx_ep_i];
  assign tx_data_o  = (tx_ep_i == 2'h3) ? 8'h00 : out_data[tx_ep_i*8 +: 8];
  assign st_sel     = sel_ok ? st_w[ep_sel_reg*5 +: 5] : `UEPR_RST_ST;

  genvar i;
  generate
    for (i = 0; i < `UEPR_NUM_EP; i = i + 1) begin : g_ep
      reg  [4:0] st_reg;
      reg  [4:0] st_next;
      reg        flag_reg;
      reg  [6:0] run_reg;
      reg  [6:0] cnt_reg;
      wire       st_wr;
      wire [4:0] st_set;
      wire       fifo_in_v;
      wire [7:0] fifo_in_d;

      assign sw_push[i] = go & wr & hit_data & (ep_sel_reg == i);
      assign sw_pop[i]  = go & ~we_i & hit_data & (ep_sel_reg == i) &
                          out_valid[i];
      assign rx_take[i] = rx_valid_i & (rx_ep_i == i) & in_ready[i] &
                          ~sw_push[i];
      assign tx_take[i] = tx_ready_i & (tx_ep_i == i) & out_valid[i] &
                          ~sw_pop[i];
      assign fifo_in_v  = sw_push[i] | rx_take[i];
      assign fifo_in_d  = sw_push[i] ? dat_i : rx_data_i;
      assign st_wr      = go & wr & (idx == `UEPR_IDX_STATUS) &
                          (ep_sel_reg == i);
      assign st_set     = {ev_outb1_i[i], ev_stall_crc_i[i], ev_setup_i[i],
                           ev_outb0_i[i], ev_tx_done_i[i]};
      assign st_w[i*5 +: 5] = st_reg;
      assign flag[i]        = flag_reg;
      assign cnt_w[i*7 +: 7] = cnt_reg;

      uepr_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH),
        .AW    (AW)
      ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .clr_i       (flush_reg[i]),
        .in_valid_i  (fifo_in_v),
        .in_ready_o  (in_ready[i]),
        .in_data_i   (fifo_in_d),
        .out_valid_o (out_valid[i]),
        .out_ready_i (sw_pop[i] | tx_take[i]),
        .out_data_o  (out_data[i*8 +: 8])
      );

      // software clears a flag by writing zero; a same-cycle event wins
      always @* begin
        st_next = st_reg;
        if (st_wr) begin
          st_next = st_reg & {dat_i[`UEPR_ST_OUTB1], dat_i[`UEPR_ST_STALL],
                              dat_i[`UEPR_ST_SETUP], dat_i[`UEPR_ST_OUTB0],
                              dat_i[`UEPR_ST_TXDONE]};
        end
        st_next = st_next | st_set;
        if (ev_setup_i[i]) begin
          st_next = 5'h04;
        end
      end

      always @(posedge clk_i) begin
        if (rst_i) begin
          st_reg   <= `UEPR_RST_ST;
          flag_reg <= 1'b0;
        end else begin
          st_reg   <= st_next;
          // flag follows the sources both up and down
          flag_reg <= |st_next;
        end
      end

      always @(posedge clk_i) begin
        if (rst_i || flush_reg[i]) begin
          run_reg <= `UEPR_RST_CNT;
          cnt_reg <= `UEPR_RST_CNT;
        end else if (rx_eop_i && rx_ep_i == i) begin
          cnt_reg <= rx_take[i] ? run_reg + 1'b1 : run_reg;
          run_reg <= `UEPR_RST_CNT;
        end else if (rx_take[i]) begin
          run_reg <= run_reg + 1'b1;
        end
      end
    end
  endgenerate

  // only the five event flags are kept; control bits read as zero
  always @* begin
    st_rd                   = `UEPR_RST_BYTE;
    st_rd[`UEPR_ST_TXDONE]  = st_sel[0];
    st_rd[`UEPR_ST_OUTB0]   = st_sel[1];
    st_rd[`UEPR_ST_SETUP]   = st_sel[2];
    st_rd[`UEPR_ST_STALL]   = st_sel[3];
    st_rd[`UEPR_ST_OUTB1]   = st_sel[4];
  end

  // the frame bits keep the last good value; crc flags track every sof
  always @* begin
    fhi_rd                  = `UEPR_RST_BYTE;
    fhi_rd[2:0]             = fnum_hi_reg;
    fhi_rd[`UEPR_FH_CRCERR] = crc_err_reg;
    fhi_rd[`UEPR_FH_CRCOK]  = crc_ok_reg;
  end

  // reserved bits are constant zero in every read path
  always @* begin
    rd_next = `UEPR_RST_BYTE;
    case (idx)
      `UEPR_IDX_FNUM_LO:  rd_next = fnum_lo_reg;
      `UEPR_IDX_FNUM_HI:  rd_next = fhi_rd;
      `UEPR_IDX_IRQ_EN:   rd_next = {5'h00, irq_en_reg};
      `UEPR_IDX_EP_SEL:   rd_next = {6'h00, ep_sel_reg};
      `UEPR_IDX_STATUS:   rd_next = st_rd;
      `UEPR_IDX_DATA: begin
        if (sel_ok && out_valid[ep_sel_reg]) begin
          rd_next = out_data[ep_sel_reg*8 +: 8];
        end
      end
      `UEPR_IDX_FLUSH:    rd_next = {5'h00, flush_reg};
      `UEPR_IDX_BYCNT: begin
        if (sel_ok) begin
          rd_next = {1'b0, cnt_w[ep_sel_reg*7 +: 7]};
        end
      end
      `UEPR_IDX_IRQ_FLAG: rd_next = {5'h00, flag};
      default:            rd_next = `UEPR_RST_BYTE;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= `UEPR_RST_BYTE;
    end else begin
      ack_reg <= go;
      if (go && !we_i) begin
        dat_reg <= rd_next;
      end
    end
  end

  // writes to the flag, count and frame indices fall through: read-only
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_reg <= `UEPR_RST_EP;
      flush_reg  <= `UEPR_RST_EP;
      ep_sel_reg <= `UEPR_RST_SEL;
    end else if (go && wr) begin
      case (idx)
        `UEPR_IDX_IRQ_EN: irq_en_reg <= dat_i[2:0];
        `UEPR_IDX_FLUSH:  flush_reg  <= dat_i[2:0];
        `UEPR_IDX_EP_SEL: ep_sel_reg <= dat_i[1:0];
        default: begin
        end
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      fnum_lo_reg <= `UEPR_RST_BYTE;
      fnum_hi_reg <= `UEPR_RST_FHI;
      crc_ok_reg  <= 1'b0;
      crc_err_reg <= 1'b0;
    end else if (sof_valid_i) begin
      crc_ok_reg  <= sof_crc_ok_i;
      crc_err_reg <= ~sof_crc_ok_i;
      if (sof_crc_ok_i) begin
        fnum_lo_reg <= sof_frame_i[7:0];
        fnum_hi_reg <= sof_frame_i[10:8];
      end
    end
  end
endmodule

/* bench/uepr_properties.sv */
// port assertions for the endpoint register block
// assumes a classic bus master holding each request until ack
`timescale 1ns/1ps
module uepr_properties (
  input wire       clk_i,
  input wire       rst_i,
  input wire       cyc_i,
  input wire       stb_i,
  input wire       we_i,
  input wire [9:0] adr_i,
  input wire       sel_i,
  input wire [7:0] dat_i,
  input wire [7:0] dat_o,
  input wire       ack_o,
  input wire       usb_irq_o,
  input wire       rx_ready_o,
  input wire [1:0] tx_ep_i,
  input wire       tx_valid_o
);
  wire [7:0] idx = adr_i[9:2];
  wire       rd  = ack_o && !we_i;
  wire       wr  = cyc_i && stb_i && we_i && sel_i && !ack_o;
  reg  [2:0] en_reg;
  reg  [2:0] fl_reg;
  // shadows of enable and flush, taken at the same edge as the block
  always @(posedge clk_i) begin
    if (rst_i) begin
      en_reg <= 3'h0;
      fl_reg <= 3'h0;
    end else if (wr && idx == 8'hC2)
      en_reg <= dat_i[2:0];
    else if (wr && idx == 8'hD5)
      fl_reg <= dat_i[2:0];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // data writes may stall on a full fifo, so they are left out
  sequence s_req; cyc_i && stb_i && !ack_o && !(we_i && idx == 8'hCF);
  endsequence
  sequence s_ack; ack_o ##1 !ack_o; endsequence
  a_ack_prompt: assert property (s_req |=> s_ack)
    else $error("access not answered in one cycle");
  a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i))
    else $error("ack without request");
  a_upper_zero: assert property (rd && (idx == 8'hC2 ||
    idx == 8'hD5 || idx == 8'hF8) |-> dat_o[7:3] == 5'h00)
    else $error("reserved bits read set");
  a_count_msb: assert property (rd && idx == 8'hE2 |-> !dat_o[7])
    else $error("count top bit set");
  a_status_five: assert property (rd && idx == 8'hCE |->
    (dat_o & 8'hB0) == 8'h00)
    else $error("status bit beyond the five sources");
  a_irq_gate: assert property (usb_irq_o |-> en_reg != 3'h0)
    else $error("irq with all endpoints disabled");
  a_flush_empty: assert property (
    (fl_reg & $past(fl_reg) & (3'h1 << tx_ep_i)) != 3'h0 |-> !tx_valid_o)
    else $error("flushed endpoint offers data");
  a_reset_idle: assert property ($fell(rst_i) |->
    rx_ready_o && !tx_valid_o && !usb_irq_o && !ack_o)
    else $error("outputs not idle after reset");
endmodule
bind uepr_top uepr_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .usb_irq_o(usb_irq_o),
  .rx_ready_o(rx_ready_o), .tx_ep_i(tx_ep_i), .tx_valid_o(tx_valid_o));

/* bench/uepr_engine_model.sv */
// packet engine stand-in: streams rx packets, drains tx never, always or at random by mode
// assumes ready from the block is sampled at the rising edge
`timescale 1ns/1ps
module uepr_engine_model (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       send_i,
  input  wire [1:0] ep_i,
  input  wire [6:0] len_i,
  input  wire [1:0] mode_i,
  input  wire       rx_ready_i,
  output reg        rx_valid_o,
  output reg  [1:0] rx_ep_o,
  output reg  [7:0] rx_data_o,
  output reg        rx_eop_o,
  output reg        tx_ready_o
);
  reg [6:0] left_reg;
  always @(posedge clk_i) begin
    tx_ready_o <= mode_i[1] | (mode_i[0] & ($urandom % 3 == 0));
    rx_eop_o <= 1'b0;
    if (rst_i) begin
      rx_valid_o <= 1'b0;
      rx_ep_o <= 2'h3;
      rx_data_o <= 8'h00;
      left_reg <= 7'h00;
    end else if (send_i) begin
      rx_valid_o <= 1'b1;
      rx_ep_o <= ep_i;
      rx_data_o <= 8'hA0;
      left_reg <= len_i;
    end else if (rx_valid_o && rx_ready_i) begin
      // after the last byte the data line shows its inverse, not stale
      rx_valid_o <= left_reg != 7'h01;
      rx_eop_o <= left_reg == 7'h01;
      rx_data_o <= left_reg == 7'h01 ? ~rx_data_o : rx_data_o + 8'h01;
      left_reg <= left_reg - 7'h01;
    end
  end
endmodule

/* bench/test_usb_endpoint_reg_interface.sv */
// self-checking bench for the endpoint register block
// assumes design, engine model and checker are compiled before it
`timescale 1ns/1ps
module test_usb_endpoint_reg_interface;
  localparam [39:0] RT = 40'h10BAE2F8D5;
  localparam [14:0] SB = {3'h3, 3'h2, 3'h6, 3'h1, 3'h0};
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc   = 1'b0;
  reg         sel   = 1'b0;
  reg         bsel  = 1'b1;
  reg         we    = 1'b0;
  reg  [9:0]  adr   = 10'h000;
  reg  [7:0]  wd    = 8'h00;
  reg  [14:0] ev    = 15'h0000;
  reg  [1:0]  ep    = 2'h0;
  reg  [1:0]  txe   = 2'h3;
  reg  [1:0]  mode  = 2'h0;
  reg  [6:0]  len   = 7'h00;
  reg         send  = 1'b0;
  reg         sof   = 1'b0;
  reg         ok    = 1'b0;
  reg  [10:0] fr    = 11'h000;
  reg  [10:0] f;
  reg  [7:0]  rd, en, txq[$];
  wire [7:0]  dat_o, rx_d, tx_d;
  wire [1:0]  rx_ep;
  wire        ack, irq, rx_v, rx_r, eop, tx_r, tx_v;
  integer     fail_count = 0, comparisons = 0, ticks = 0, i, j, n;
  uepr_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(dat_o),
    .ack_o(ack), .usb_irq_o(irq), .ev_tx_done_i(ev[2:0]),
    .ev_outb0_i(ev[5:3]), .ev_outb1_i(ev[8:6]), .ev_setup_i(ev[11:9]),
    .ev_stall_crc_i(ev[14:12]), .rx_valid_i(rx_v), .rx_ep_i(rx_ep),
    .rx_data_i(rx_d), .rx_ready_o(rx_r), .rx_eop_i(eop), .tx_ep_i(txe),
    .tx_ready_i(tx_r), .tx_valid_o(tx_v), .tx_data_o(tx_d),
    .sof_valid_i(sof), .sof_crc_ok_i(ok), .sof_frame_i(fr));
  uepr_engine_model peer (.clk_i(clk_i), .rst_i(rst_i), .send_i(send),
    .ep_i(ep), .len_i(len), .mode_i(mode), .rx_ready_i(rx_r),
    .rx_valid_o(rx_v), .rx_ep_o(rx_ep), .rx_data_o(rx_d),
    .rx_eop_o(eop), .tx_ready_o(tx_r));
  always #25 clk_i = ~clk_i;
  task automatic check(input string name, input [7:0] seen,
                       input [7:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // entered and left at a rising edge; leaves one idle cycle behind
  task wb(input w, input [7:0] a, input [7:0] d);
    cyc <= 1'b1;
    sel <= bsel;
    we <= w;
    adr <= {a, 2'b00};
    wd <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task packet(input [1:0] p, input [6:0] l);
    ep <= p;
    len <= l;
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    while (eop !== 1'b1) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    ticks = ticks + 1;
    if (tx_v === 1'b1 && tx_r === 1'b1)
      check("tx byte", tx_d, txq.pop_front());
    if (ticks == 20000) begin
      fail_count = fail_count + 1;
      wrap_up;
    end
  end
  initial begin
    n = $urandom(32'h7FFD);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 5; i++) begin
      wb(0, RT[i*8 +: 8], 8'h00);
      check("reset value", rd, 8'h00);
    end
    $display("reset value tests done");
    wb(1, 8'hD5, 8'h07);
    wb(0, 8'hD5, 8'h00);
    check("flush bits", rd, 8'h07);
    wb(1, 8'hD5, 8'h00);
    en = 8'h01 + $urandom % 6;
    wb(1, 8'hC2, en);
    wb(0, 8'hC2, 8'h00);
    check("irq enable", rd, en);
    bsel = 1'b0;
    wb(1, 8'hC2, ~en);
    bsel = 1'b1;
    wb(0, 8'hC2, 8'h00);
    check("byte select", rd, en);
    for (i = 0; i < 3; i++)
      for (j = 0; j < 5; j++) begin
        ev <= 15'h0001 << (j * 3 + i);
        @(posedge clk_i);
        ev <= 15'h0000;
        wb(1, 8'hF8, 8'h00);
        wb(0, 8'hF8, 8'h00);
        check("irq flags", rd, 8'h01 << i);
        check("irq line", {7'h00, irq}, {7'h00, en[i]});
        wb(1, 8'hC7, i[7:0]);
        wb(0, 8'hCE, 8'h00);
        check("status", rd, 8'h01 << SB[j*3 +: 3]);
        wb(1, 8'hCE, 8'h00);
        wb(0, 8'hF8, 8'h00);
        check("flag cleared", rd, 8'h00);
      end
    ev <= 15'h0001;
    @(posedge clk_i);
    ev <= 15'h0201;
    @(posedge clk_i);
    ev <= 15'h0000;
    wb(1, 8'hC7, 8'h00);
    wb(0, 8'hCE, 8'h00);
    check("setup status", rd, 8'h04);
    wb(1, 8'hCE, 8'h00);
    $display("irq tests done");
    for (i = 0; i < 3; i++) begin
      n = 1 + $urandom % 8;
      wb(1, 8'hC7, i[7:0]);
      packet(i[1:0], n[6:0]);
      wb(0, 8'hE2, 8'h00);
      check("byte count", rd, n[7:0]);
      for (j = 0; j <= n; j++) begin
        wb(0, 8'hCF, 8'h00);
        check("rx byte", rd, j < n ? 8'hA0 + j : 8'h00);
      end
    end
    wb(1, 8'hD5, 8'h02);
    txe <= 2'h1;
    wb(1, 8'hC7, 8'h01);
    packet(2'h1, 7'h03);
    wb(0, 8'hE2, 8'h00);
    check("flushed count", rd, 8'h00);
    wb(0, 8'hCF, 8'h00);
    check("flushed fifo", rd, 8'h00);
    wb(1, 8'hD5, 8'h00);
    $display("rx tests done");
    for (j = 0; j < 9; j++) begin
      n = $urandom;
      txq.push_back(n[7:0]);
      if (j == 8)
        mode <= 2'h1;
      wb(1, 8'hCF, n[7:0]);
    end
    while (txq.size() > 0) @(posedge clk_i);
    @(posedge clk_i);
    check("drained", {7'h00, tx_v}, 8'h00);
    $display("tx tests done");
    f = $urandom;
    for (i = 0; i < 2; i++) begin
      fr <= i ? ~f : f;
      ok <= !i;
      sof <= 1'b1;
      @(posedge clk_i);
      sof <= 1'b0;
      wb(0, 8'hBA, 8'h00);
      check("frame low", rd, f[7:0]);
      wb(0, 8'hBB, 8'h00);
      check("frame high", rd, {2'h0, !i, i[0], 1'b0, f[10:8]});
    end
    $display("frame tests done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, 8'hBA, 8'h00);
    check("frame after reset", rd, 8'h00);
    wb(0, 8'hC2, 8'h00);
    check("enable after reset", rd, 8'h00);
    wb(1, 8'hD5, 8'h07);
    wb(1, 8'hD5, 8'h00);
    $display("mid-run reset tests done");
    wrap_up;
  end
endmodule
